// File: hw/rrot_regs.svh
// constants for the return and rotate instruction executor
`ifndef RROT_REGS_SVH
`define RROT_REGS_SVH
`define RROT_GIE_BIT 7
`define RROT_CARRY_BIT 0
`define RROT_MSB 7
`define RROT_RET_CYCLES 2'h2
`define RROT_ONE_CYCLE 2'h1
`define RROT_CODE_RETURN 14'h0008
`define RROT_CODE_INT_RETURN 14'h0009
`define RROT_OP_MSB 13
`define RROT_LIT_RETURN_LSB 10
`define RROT_ROTATE_LSB 8
`define RROT_LIT_MSB 7
`define RROT_ADDR_MSB 6
`define RROT_LIT_RETURN_HI 4'hd
`define RROT_ROTATE_HI 6'h0d
`define RROT_ROTATE_TOP 4'h0
`define RROT_DEST_BIT 7
`endif

// File: hw/rrot_pkg.sv
// types for the return and rotate instruction executor
package rrot_pkg;
    typedef enum logic [2:0] {RROT_NONE, RROT_RET, RROT_IRET, RROT_LRET, RROT_RLF} rrot_op_t;
    typedef enum logic [1:0] {RROT_IDLE, RROT_FLUSH} rrot_state_t;
endpackage : rrot_pkg

// File: hw/rrot_exec.sv
// executor for return, literal return, interrupt return and rotate left through carry
`timescale 1ns/100ps
`default_nettype none
`include "rrot_regs.svh"
module rrot_exec import rrot_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [12:0] stack_top,
    input wire logic [7:0] file_rdata,
    input wire logic carry_in,
    input wire logic [7:0] interrupt_control_reg_in,
    output logic instr_ready,
    output logic stack_pop,
    output logic pc_load,
    output logic [12:0] pc_value,
    output logic w_we,
    output logic [7:0] w_data,
    output logic file_we,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    output logic carry_we,
    output logic carry_out,
    output logic interrupt_control_reg_we,
    output logic [7:0] interrupt_control_reg_data
);
    // classify one instruction word; all other codes are ignored here
    function automatic rrot_op_t rrot_decode(input logic [13:0] w);
        rrot_op_t r;
        r = RROT_NONE;
        if (w == `RROT_CODE_RETURN) begin
            r = RROT_RET;
        end else if (w == `RROT_CODE_INT_RETURN) begin
            r = RROT_IRET;
        end else if (w[`RROT_OP_MSB:`RROT_LIT_RETURN_LSB] == `RROT_LIT_RETURN_HI) begin
            r = RROT_LRET;
        end else if (w[`RROT_OP_MSB:`RROT_ROTATE_LSB] == `RROT_ROTATE_HI) begin
            r = RROT_RLF;
        end
        return r;
    endfunction : rrot_decode

    // the three return forms share the pop, the program counter load and the flush cycle
    function automatic logic rrot_is_return(input rrot_op_t o);
        return o == RROT_RET || o == RROT_IRET || o == RROT_LRET;
    endfunction : rrot_is_return

    rrot_op_t op;
    rrot_state_t state_ff;
    logic [7:0] rot_val;
    logic go;
    logic ret_go;

    assign op = rrot_decode(instr_word);
    assign go = clk_en && instr_valid && instr_ready;
    assign ret_go = go && rrot_is_return(op);
    assign rot_val = {file_rdata[`RROT_MSB-1:0], carry_in};

    // returns take a second flush cycle; no new instruction in that cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= RROT_IDLE;
            instr_ready <= 1'b1;
        end else if (clk_en) begin
            unique case (state_ff)
                RROT_IDLE: begin
                    if (ret_go) begin
                        state_ff <= RROT_FLUSH;
                        instr_ready <= 1'b0;
                    end
                end
                RROT_FLUSH: begin
                    state_ff <= RROT_IDLE;
                    instr_ready <= 1'b1;
                end
                default: begin
                    state_ff <= RROT_IDLE;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    // program counter and stack
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stack_pop <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= 13'h0000;
        end else if (clk_en) begin
            stack_pop <= ret_go;
            pc_load <= ret_go;
            if (go) begin
                pc_value <= stack_top;
            end
        end
    end

    // working register: literal of a literal return, or the rotate result for destination 0
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_we <= 1'b0;
            w_data <= 8'h00;
        end else if (clk_en) begin
            w_we <= go && (op == RROT_LRET || (op == RROT_RLF && !instr_word[`RROT_DEST_BIT]));
            if (go) begin
                w_data <= (op == RROT_LRET) ? instr_word[`RROT_LIT_MSB:0] : rot_val;
            end
        end
    end

    // file write-back; data holds until the next take so a slow consumer still sees it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_we <= 1'b0;
            file_addr <= 7'h00;
            file_wdata <= 8'h00;
        end else if (clk_en) begin
            file_we <= go && op == RROT_RLF && instr_word[`RROT_DEST_BIT];
            if (go) begin
                file_addr <= instr_word[`RROT_ADDR_MSB:0];
                file_wdata <= rot_val;
            end
        end
    end

    // carry flag: the only status bit that any of these instructions touches
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            carry_we <= 1'b0;
            carry_out <= 1'b0;
        end else if (clk_en) begin
            carry_we <= go && op == RROT_RLF;
            if (go) begin
                carry_out <= file_rdata[`RROT_MSB];
            end
        end
    end

    // only the enable bit is forced; the rest of the control value passes through unchanged
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interrupt_control_reg_we <= 1'b0;
            interrupt_control_reg_data <= 8'h00;
        end else if (clk_en) begin
            interrupt_control_reg_we <= go && op == RROT_IRET;
            if (go) begin
                interrupt_control_reg_data <= interrupt_control_reg_in | (8'h01 << `RROT_GIE_BIT);
            end
        end
    end

    // enabled cycles spent held off; a return may hold the core for one cycle only
    logic [1:0] hold_cnt_ff;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt_ff <= 2'h0;
        end else if (clk_en) begin
            hold_cnt_ff <= instr_ready ? 2'h0 : hold_cnt_ff + `RROT_ONE_CYCLE;
        end
    end

    // only rotate may touch carry; returns never do
    no_flag_ret_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pc_load |-> !carry_we) else $error("return touched carry");
    iret_gie_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        interrupt_control_reg_we |-> interrupt_control_reg_data[`RROT_GIE_BIT] && pc_load) else $error("interrupt return missing enable");
    ret_two_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clk_en && pc_load |-> !instr_ready) else $error("return not two cycles");
    rot_one_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        carry_we |-> instr_ready) else $error("rotate stalled");
    rot_dest_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        carry_we |-> (w_we != file_we)) else $error("rotate destination wrong");
    rot_val_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        file_we |-> file_wdata == w_data) else $error("rotate value mismatch");

    // a return is taken at one edge, pops at the next, then frees the core
    sequence ret_take_s;
        ret_go;
    endsequence : ret_take_s

    sequence ret_pop_s;
        stack_pop && pc_load && !instr_ready;
    endsequence : ret_pop_s

    sequence ret_free_s;
        instr_ready && !stack_pop && !pc_load;
    endsequence : ret_free_s

    ret_pop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ret_take_s |=> ret_pop_s) else $error("return did not pop");
    ret_free_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ret_pop_s ##0 clk_en |=> ret_free_s) else $error("return held core too long");
    ret_pc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ret_take_s |=> pc_value == $past(stack_top)) else $error("program counter not from stack");
    ret_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hold_cnt_ff < `RROT_RET_CYCLES) else $error("return longer than two cycles");
    ret_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_RET) |=> !w_we && !file_we && !carry_we && !interrupt_control_reg_we) else $error("return wrote data");
    lret_w_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_LRET) |=> w_we && w_data == $past(instr_word[`RROT_LIT_MSB:0])) else $error("literal lost");
    iret_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_IRET) |=> interrupt_control_reg_we && interrupt_control_reg_data == ($past(interrupt_control_reg_in) | (8'h01 << `RROT_GIE_BIT)))
        else $error("interrupt enable not set");

    // rotate checks look back one edge at what the core presented
    rot_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_RLF) |=> carry_we && carry_out == $past(file_rdata[`RROT_MSB])) else $error("carry wrong");
    rot_shift_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_RLF) |=> file_wdata == {$past(file_rdata[`RROT_MSB-1:0]), $past(carry_in)})
        else $error("rotate shift wrong");
    rot_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_RLF) |=> file_addr == $past(instr_word[`RROT_ADDR_MSB:0])) else $error("rotate address wrong");
    rot_wdest_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (go && op == RROT_RLF && !instr_word[`RROT_DEST_BIT]) |=> w_we && !file_we) else $error("rotate not to w");
    rot_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        carry_we |-> !stack_pop && !interrupt_control_reg_we) else $error("rotate touched more than carry");
endmodule : rrot_exec
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the return and rotate executor
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk = 0, sys_rst = 1, clk_en = 1, instr_valid = 0, carry_in = 0;
    logic [13:0] instr_word = 14'h0, w;
    logic [12:0] stack_top = 13'h0, pc_value;
    logic [7:0] file_rdata = 8'h0, interrupt_control_reg_in = 8'h0, w_data, file_wdata, interrupt_control_reg_data;
    logic instr_ready, stack_pop, pc_load, w_we, file_we, carry_we, carry_out, interrupt_control_reg_we;
    logic [6:0] file_addr;
    logic [31:0] seed = 32'h77dd7898;
    int fails = 0, samples_checked = 0;
    wire logic [5:0] strb = {stack_pop, pc_load, w_we, file_we, carry_we, interrupt_control_reg_we};
    rrot_exec rrot_exec_inst (.sys_clk, .sys_rst, .clk_en, .instr_valid, .instr_word, .stack_top, .file_rdata,
        .carry_in, .interrupt_control_reg_in, .instr_ready, .stack_pop, .pc_load, .pc_value, .w_we, .w_data, .file_we,
        .file_addr, .file_wdata, .carry_we, .carry_out, .interrupt_control_reg_we, .interrupt_control_reg_data);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // rotate left through carry: new carry, then the shifted value with the old carry at the bottom
    function automatic logic [8:0] rot_exp(input logic [7:0] f, input logic c);
        return {f[7], f[6:0], c};
    endfunction : rot_exp
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // one instruction; a return holds the core off for a second cycle
    task automatic issue(input logic [13:0] op, input logic [7:0] rd, input logic c);
        logic rot, lret, iret, pop;
        int n;
        n = 0;
        while (instr_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 8) begin
                fails++;
                end_of_test();
            end
        end
        seed = xs(seed);
        stack_top = seed[12:0];
        interrupt_control_reg_in = seed[20:13];
        instr_word = op;
        file_rdata = rd;
        carry_in = c;
        instr_valid = 1;
        rot = op[13:8] == 6'h0d;
        lret = op[13:10] == 4'hd;
        iret = op == 14'h0009;
        pop = lret || iret || op == 14'h0008;
        @(posedge sys_clk);
        #1;
        chk(strb, {pop, pop, lret | (rot & ~op[7]), rot & op[7], rot, iret});
        chk(instr_ready, !pop);
        if (pop) chk(pc_value, stack_top);
        if (lret) chk(w_data, op[7:0]);
        if (iret) chk(interrupt_control_reg_data, interrupt_control_reg_in | 8'h80);
        if (rot) chk({carry_out, op[7] ? file_wdata : w_data}, rot_exp(rd, c));
        if (rot && op[7]) chk(file_addr, op[6:0]);
        if (pop) begin
            @(posedge sys_clk);
            #1;
            chk({strb, instr_ready}, 7'h01);
        end
    endtask : issue
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        chk({strb, instr_ready}, 7'h01);
        sys_rst = 0;
        issue(14'h0d05, 8'he6, 1'b0);
        issue(14'h0dff, 8'h80, 1'b1);
        issue(14'h0d80, 8'h7f, 1'b0);
        issue(14'h0008, 8'h00, 1'b0);
        issue(14'h3400, 8'h00, 1'b0);
        issue(14'h37ff, 8'h00, 1'b0);
        issue(14'h0009, 8'h00, 1'b0);
        // a frozen core must ignore a pending rotate
        clk_en = 0;
        instr_word = 14'h0d85;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(strb, 6'h00);
        clk_en = 1;
        for (int i = 0; i < 300; i++) begin
            seed = xs(seed);
            case (seed[10:8])
                3'h0: w = 14'h0008;
                3'h1: w = 14'h0009;
                3'h2, 3'h3: w = {4'hd, seed[31:22]};
                3'h4, 3'h5, 3'h6: w = {6'h0d, seed[29:22]};
                default: w = {2'h2, seed[31:20]};
            endcase
            issue(w, seed[19:12], seed[11]);
        end
        instr_valid = 0;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
